// ---- hdl/esp_top.sv ----
// Purpose: Serial memory slave with command decode and write protection
// Assumes: Link pins are asynchronous and oversampled by CLK
// Notes: Serial clock mode 0; array kept in flip-flops
//
// Summary of operation
// R1: Select falls to start; all fields MSB first
// R2: Decode latch set and latch clear opcodes
// R3: Decode status read and status write opcodes
// R4: Decode array read and array write opcodes
// R5: Write enable latch clear after power-up
// R6: Status bit 0 shows write in progress
// R7: Status bit 1 shows write enable latch
// R8: Status bits 6..4 read zero when idle
// R9: Status reads all ones while writing
// R10: Block protect bits choose protected region
// R11: Protect bits nonvolatile, programmed by timed cycle
// R12: Hardware protect when pin low and enabled
// R13: Hardware protect blocks status writes entirely
// R14: Protect enable cannot clear while pin low
// R15: Read sends command, address, then data out
// R16: Sequential read increments, wraps to zero
// R17: Array write needs latch, unprotected address
// R18: Busy ignores all but status read
// R19: Programming starts on select rise after byte
// R20: Page of 64 bytes, low bits wrap
// R21: Latch clears when write cycle completes
// R22: Write with latch clear is ignored
// R23: Unknown opcode ignored until next select
// R24: Deselected: input ignored, output released
// R25: Pause pin suspends and resumes transfer
// R26: Two address bytes, upper bits ignored
// R27: Sample input on rise, shift on fall
`timescale 1ns/10ps
`default_nettype none
`include "esp_defines.svh"

module esp_top #(
    parameter int ADDR_W = 15,
    parameter int WRITE_CYCLES = `ESP_WRITE_TIME_MS * `ESP_CLK_KHZ
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Serial link pins
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SI,
    output logic SO,
    output logic SO_OE,
    // Protect and pause pins
    input wire logic WP_N,
    input wire logic HOLD_N,
    // Device state
    output logic BUSY,
    output logic [7:0] STATUS,
    output var esp_pkg::esp_state_type PHASE
);
    import esp_pkg::*;

    localparam int PB = `ESP_PAGE_BITS;
    localparam int PAGE = 2 ** PB;

    // Opcode match, bit 3 don't care
    function automatic logic op_is(input logic [7:0] c, input logic [2:0] o);
        op_is = (c[7:4] == 4'h0) && (c[2:0] == o);
    endfunction

    // R10 block-protected region check
    function automatic logic in_block(input logic [ADDR_W-1:0] a,
                                      input logic [1:0] b);
        case (b)
            2'b01: in_block = &a[ADDR_W-1 -: 2];
            2'b10: in_block = a[ADDR_W-1];
            2'b11: in_block = 1'b1;
            default: in_block = 1'b0;
        endcase
    endfunction

    logic [4:0] pin_meta; // First sync stage, read only by next
    logic [4:0] pin_sync; // Second sync stage
    logic sck_prev; // Edge detect history
    logic cs_prev; // Select edge history
    logic paused; // Pause active
    esp_state_type state; // Transfer phase
    logic [2:0] bit_cnt; // Bit within byte
    logic [7:0] shreg; // Input shift register
    logic [7:0] out_byte; // Byte being shifted out
    logic [7:0] addr_hi; // First address byte
    logic addr_second; // Waiting for second address byte
    logic rd_mode; // Address phase leads to a read
    logic [ADDR_W-1:0] addr; // Address counter
    logic [7:0] page_buf [PAGE]; // Page staging bytes
    logic [PAGE-1:0] page_vld; // Staged byte flags
    logic [7:0] sr_pend; // Pending status value
    logic sr_got; // Status data byte complete
    logic [7:0] mem [2**ADDR_W]; // Array storage
    logic busy; // Internal write cycle
    logic [31:0] wcnt; // Write cycle timer
    logic [PB-1:0] commit_idx; // Page commit walker
    logic pg_prog; // Cycle programs the page
    logic sr_prog; // Cycle programs status bits
    logic latch; // Write enable latch
    logic ppe; // Protect pin enable
    logic [1:0] bp; // Block protect {hi, lo}

    // Synchronised pins
    logic cs_n, sck, si, wp_n, hold_n;
    assign cs_n = pin_sync[4];
    assign sck = pin_sync[3];
    assign si = pin_sync[2];
    assign wp_n = pin_sync[1];
    assign hold_n = pin_sync[0];

    // Events derived from the pins
    logic cs_fall, cs_rise, sck_rise, sck_fall, live, byte_done;
    logic [7:0] rx;
    logic hw_prot, wr_done, start_page, start_sr;
    logic latch_set_hit, latch_clear_hit;
    logic [7:0] status_view;
    logic [ADDR_W-1:0] next_addr, full_addr;

    assign cs_fall = !cs_n && cs_prev;
    assign cs_rise = cs_n && !cs_prev;
    assign sck_rise = sck && !sck_prev;
    assign sck_fall = !sck && sck_prev;
    // R24 deselected ignores input
    assign live = !cs_n && !paused && !cs_fall;
    // R27 sample on rising edge
    assign byte_done = live && sck_rise && (bit_cnt == 3'h7);
    // R1 shift in MSB first
    assign rx = {shreg[6:0], si};
    assign next_addr = addr + 1'b1;
    // R26 keep only the low address bits
    assign full_addr = ADDR_W'({addr_hi, rx});
    // R12 hardware protection
    assign hw_prot = !wp_n && ppe;
    assign wr_done = busy && (wcnt == 32'(WRITE_CYCLES - 1));
    // R19 program only after a whole byte
    assign start_page = cs_rise && (state == ST_WDATA) &&
                        (bit_cnt == 3'h0) && (|page_vld);
    // R13 status write refused under hardware protect
    assign start_sr = cs_rise && (state == ST_SWR) && sr_got &&
                      (bit_cnt == 3'h0) && !hw_prot;
    // R2 latch commands, not while busy
    assign latch_set_hit = byte_done && (state == ST_CMD) && !busy &&
                           op_is(rx, `ESP_OPC_LATCH_SET);
    assign latch_clear_hit = byte_done && (state == ST_CMD) && !busy &&
                             op_is(rx, `ESP_OPC_LATCH_CLEAR);

    // R6 R7 R8 status as link sees it
    always_comb begin
        status_view = 8'h00;
        status_view[`ESP_SR_BUSY] = busy;
        status_view[`ESP_SR_LATCH] = latch;
        status_view[`ESP_SR_BP_LO] = bp[0];
        status_view[`ESP_SR_BP_HI] = bp[1];
        status_view[`ESP_SR_PPE] = ppe;
        // R9 all ones while writing
        if (busy) begin
            status_view = `ESP_SR_ALL_ONES;
        end
    end

    // Two-flop pin synchronisers
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pin_meta <= `ESP_PIN_IDLE;
            pin_sync <= `ESP_PIN_IDLE;
            sck_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            pin_meta <= {CS_N, SCK, SI, WP_N, HOLD_N};
            pin_sync <= pin_meta;
            sck_prev <= sck;
            cs_prev <= cs_n;
        end
    end

    // Pause tracking, set or released while the clock is low, cleared whenever deselected
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            paused <= 1'b0;
        end else if (cs_n) begin
            paused <= 1'b0;
        // R25 pause and resume at clock low
        end else if (!sck) begin
            paused <= !hold_n;
        end
    end

    // Transfer sequencer
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            out_byte <= 8'h00;
            addr_hi <= 8'h00;
            addr_second <= 1'b0;
            rd_mode <= 1'b0;
            addr <= '0;
            page_vld <= '0;
            sr_pend <= 8'h00;
            sr_got <= 1'b0;
        // R1 select falling starts a transaction
        end else if (cs_fall) begin
            state <= ST_CMD;
            bit_cnt <= 3'h0;
        // R24 back to standby when deselected
        end else if (cs_n) begin
            state <= ST_IDLE;
        end else if (live && sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            shreg <= rx;
            if (bit_cnt == 3'h7) begin
                case (state)
                    ST_CMD: begin
                        state <= ST_IGNORE;
                        // R3 R18 status read always served
                        if (op_is(rx, `ESP_OPC_STATUS_READ)) begin
                            state <= ST_SRD;
                            out_byte <= status_view;
                        end else if (busy) begin
                            state <= ST_IGNORE;
                        // R22 writes need the latch
                        end else if (op_is(rx, `ESP_OPC_STATUS_WRITE)) begin
                            if (latch) begin
                                state <= ST_SWR;
                                sr_got <= 1'b0;
                            end
                        // R4 array read and write
                        end else if (op_is(rx, `ESP_OPC_ARRAY_READ)) begin
                            state <= ST_ADDR;
                            rd_mode <= 1'b1;
                            addr_second <= 1'b0;
                        end else if (op_is(rx, `ESP_OPC_ARRAY_WRITE)) begin
                            if (latch) begin
                                state <= ST_ADDR;
                                rd_mode <= 1'b0;
                                addr_second <= 1'b0;
                                page_vld <= '0;
                            end
                        end
                        // R23 anything else is ignored
                    end
                    ST_ADDR: begin
                        // R26 high byte then low byte
                        if (!addr_second) begin
                            addr_hi <= rx;
                            addr_second <= 1'b1;
                        end else begin
                            addr <= full_addr;
                            // R15 read data follows address
                            if (rd_mode) begin
                                state <= ST_RDATA;
                                out_byte <= mem[full_addr];
                            end else begin
                                state <= ST_WDATA;
                            end
                        end
                    end
                    ST_RDATA: begin
                        // R16 increment and wrap
                        addr <= next_addr;
                        out_byte <= mem[next_addr];
                    end
                    ST_WDATA: begin
                        // R17 protected bytes are dropped
                        if (!in_block(addr, bp)) begin
                            page_buf[addr[PB-1:0]] <= rx;
                            page_vld[addr[PB-1:0]] <= 1'b1;
                        end
                        // R20 only the page offset advances
                        addr[PB-1:0] <= addr[PB-1:0] + 1'b1;
                    end
                    ST_SWR: begin
                        // Stay here so select rise can start the cycle
                        sr_pend <= rx;
                        sr_got <= 1'b1;
                    end
                    ST_SRD: begin
                        out_byte <= status_view;
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // Serial output, driven only in read phases
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            SO <= 1'b0;
            SO_OE <= 1'b0;
        // R24 R25 released when deselected or paused
        end else if (cs_n || paused) begin
            SO_OE <= 1'b0;
        end else begin
            SO_OE <= (state == ST_RDATA) || (state == ST_SRD);
            // R27 shift out after the falling edge
            if (sck_fall) begin
                SO <= out_byte[~bit_cnt];
            end
        end
    end

    // Self-timed write cycle and nonvolatile status bits
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            busy <= 1'b0;
            wcnt <= 32'h0;
            commit_idx <= '0;
            pg_prog <= 1'b0;
            sr_prog <= 1'b0;
            bp <= `ESP_BP_RESET;
            ppe <= `ESP_PPE_RESET;
        // R19 R11 a write cycle starts on select rise
        end else if (start_page || start_sr) begin
            busy <= 1'b1;
            wcnt <= 32'h0;
            commit_idx <= '0;
            pg_prog <= start_page;
            sr_prog <= start_sr;
        end else if (busy) begin
            wcnt <= wcnt + 32'h1;
            commit_idx <= commit_idx + 1'b1;
            if (wr_done) begin
                busy <= 1'b0;
                pg_prog <= 1'b0;
                sr_prog <= 1'b0;
                // R11 R14 status bits land at cycle end
                if (sr_prog) begin
                    bp <= {sr_pend[`ESP_SR_BP_HI], sr_pend[`ESP_SR_BP_LO]};
                    ppe <= sr_pend[`ESP_SR_PPE];
                end
            end
        end
    end

    // Page commit, one staged byte per clock while busy
    always_ff @(posedge CLK) begin
        if (busy && pg_prog && page_vld[commit_idx]) begin
            mem[{addr[ADDR_W-1:PB], commit_idx}] <= page_buf[commit_idx];
        end
    end

    // Write enable latch
    always_ff @(posedge CLK or posedge RESET) begin
        // R5 cleared at power-up
        if (RESET) begin
            latch <= 1'b0;
        // R21 cleared when the cycle completes
        end else if (wr_done) begin
            latch <= 1'b0;
        end else if (latch_set_hit) begin
            latch <= 1'b1;
        end else if (latch_clear_hit) begin
            latch <= 1'b0;
        end
    end

    // Visible state
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            STATUS <= 8'h00;
        end else begin
            STATUS <= status_view;
        end
    end
    assign BUSY = busy;
    assign PHASE = state;

    // Checks on the design's own behaviour
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    idle_so_hiz_a: assert property (cs_n |=> !SO_OE) // R24
        else $error("output driven while deselected");
    hold_so_hiz_a: assert property (paused |=> !SO_OE) // R25
        else $error("output driven while paused");
    busy_all_ones_a: assert property (busy |=> STATUS == 8'hff) // R9
        else $error("status not all ones while busy");
    ready_bit_a: assert property (!busy |=> !STATUS[0]) // R6
        else $error("busy bit set while ready");
    latch_bit_a: assert property (!busy |=> STATUS[1] == $past(latch)) // R7
        else $error("latch bit mismatch");
    reserved_zero_a: assert property (!busy |=> STATUS[6:4] == 3'h0) // R8
        else $error("reserved status bits not zero");
    busy_ignore_a: assert property (busy && byte_done && // R18
        state == ST_CMD && !op_is(rx, `ESP_OPC_STATUS_READ)
        |=> state == ST_IGNORE)
        else $error("command accepted while busy");
    latch_autoclr_a: assert property (wr_done |=> !latch && !busy) // R21
        else $error("latch not cleared after write cycle");
    no_latch_write_a: assert property (byte_done && // R22
        state == ST_CMD && !latch && op_is(rx, `ESP_OPC_ARRAY_WRITE)
        |=> state == ST_IGNORE)
        else $error("write accepted without latch");
    hw_reject_a: assert property (cs_rise && state == ST_SWR && hw_prot // R13
        |=> !busy ##1 !busy)
        else $error("status write under hardware protect");
    sr_commit_a: assert property (start_sr |=> busy && sr_prog) // R11
        else $error("status write did not start a cycle");
    read_wrap_a: assert property (byte_done && // R16
        state == ST_RDATA && &addr |=> addr == '0)
        else $error("read address did not wrap");
    page_fixed_a: assert property (byte_done && state == ST_WDATA // R20
        |=> addr[ADDR_W-1:PB] == $past(addr[ADDR_W-1:PB]))
        else $error("page bits moved during page write");

    read_seen_c: cover property (state == ST_RDATA && byte_done);
    page_prog_c: cover property (start_page ##1 busy);
    sr_prog_c: cover property (start_sr);
    busy_poll_c: cover property (busy && state == ST_SRD && byte_done);

endmodule
`default_nettype wire

// ---- include/esp_defines.svh ----
// Purpose: Constants for the serial nonvolatile memory command block
// Assumes: 40 MHz system clock
// Notes: Opcode values are the low three bits; bits 7..4 must be zero
`ifndef ESP_DEFINES_SVH
`define ESP_DEFINES_SVH

// Opcode low bits, bit 3 is ignored
`define ESP_OPC_LATCH_SET 3'h6
`define ESP_OPC_LATCH_CLEAR 3'h4
`define ESP_OPC_STATUS_READ 3'h5
`define ESP_OPC_STATUS_WRITE 3'h1
`define ESP_OPC_ARRAY_READ 3'h3
`define ESP_OPC_ARRAY_WRITE 3'h2

// Status register fields
`define ESP_SR_BUSY 0
`define ESP_SR_LATCH 1
`define ESP_SR_BP_LO 2
`define ESP_SR_BP_HI 3
`define ESP_SR_PPE 7
`define ESP_SR_ALL_ONES 8'hff

// Nonvolatile bit defaults at power-up
`define ESP_BP_RESET 2'h0
`define ESP_PPE_RESET 1'h0

// Pin synchroniser idle levels {cs_n, sck, si, wp_n, hold_n}
`define ESP_PIN_IDLE 5'h13

// Page size in address bits
`define ESP_PAGE_BITS 6

// Self-timed write cycle, in ms, and clock rate in kHz
`define ESP_WRITE_TIME_MS 5
`define ESP_CLK_KHZ 40000

`endif

// ---- include/esp_pkg.sv ----
// Purpose: Types for the serial nonvolatile memory command block
// Assumes: esp_defines.svh holds the numbers
// Notes: Transfer phase enumeration only
package esp_pkg;

    // Transfer phase
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_ADDR = 3'b010,
        ST_RDATA = 3'b011,
        ST_WDATA = 3'b100,
        ST_SRD = 3'b101,
        ST_SWR = 3'b110,
        ST_IGNORE = 3'b111
    } esp_state_type;

endpackage

// ---- dv/esp_spi_master.sv ----
// Purpose: Host SPI master model for the serial memory bench
// Assumes: Mode 0, SCK period of 8 CLK, pins change on CLK fall
// Notes: A released SO reads as the inverse of the last bit taken
`timescale 1ns/10ps
`default_nettype none

module esp_spi_master (
    // Clock
    input wire logic clk,
    // Link pins driven by the host
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    // Link pins driven by the device
    input wire logic so,
    input wire logic so_oe
);
    logic last_so; // Last bit taken from the SO line
    logic paused_oe; // SO enable seen while paused

    // Idle link: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        last_so = 1'b0;
        paused_oe = 1'b1;
    end

    // Wait n CLK falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic start();
        cs_n = 1'b0;
        tick(4);
    endtask

    task automatic stop();
        sck = 1'b0;
        tick(4);
        cs_n = 1'b1;
        // Stale data must not look valid to a deselected device
        si = ~si;
        tick(8);
    endtask

    // MSB first
    // A pause is taken before bit hb, with SCK low, when hb < 8
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
        input int hb);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            tick(4);
            if (i == hb) begin
                hold_n = 1'b0;
                tick(4);
                sck = 1'b1; // Toggle to prove edges are ignored
                tick(4);
                sck = 1'b0;
                tick(4);
                paused_oe = so_oe;
                hold_n = 1'b1;
                tick(8);
            end
            sck = 1'b1;
            tick(4);
            // Never trust a released line to keep its value
            last_so = so_oe ? so : ~last_so;
            rx[i] = last_so;
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the serial memory command block
// Assumes: 8 address bits and a short write cycle in simulation
// Notes: Expected memory contents kept in a small mirror
`timescale 1ns/10ps
`default_nettype none
`include "esp_defines.svh"

module tb_top;
    import esp_pkg::*;
    localparam int WCYC = 400; // Shortened write cycle length
    logic CLK, RESET, CS_N, SCK, SI, SO, SO_OE, WP_N, HOLD_N, BUSY;
    logic [7:0] STATUS;
    esp_state_type PHASE;
    int fail_count = 0;
    int n_tests = 0;
    logic [7:0] wbuf [4]; // Bytes for the next frame
    logic [7:0] rbuf [4]; // Bytes from the last frame
    logic [7:0] mir [3]; // Expected probe contents
    logic [7:0] rx; // Scratch receive byte
    logic [7:0] probe [3] = '{8'h00, 8'h80, 8'hc0}; // One per region

    // 40 MHz clock
    initial CLK = 1'b0;
    always #12.5 CLK = ~CLK;

    esp_top #(.ADDR_W(8), .WRITE_CYCLES(WCYC)) dut (.CLK(CLK),
        .RESET(RESET), .CS_N(CS_N), .SCK(SCK), .SI(SI), .SO(SO),
        .SO_OE(SO_OE), .WP_N(WP_N), .HOLD_N(HOLD_N), .BUSY(BUSY),
        .STATUS(STATUS), .PHASE(PHASE));

    esp_spi_master m (.clk(CLK), .cs_n(CS_N), .sck(SCK), .si(SI),
        .hold_n(HOLD_N), .so(SO), .so_oe(SO_OE));

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Counts, verdict, end of run
    task automatic conclude();
        $display("Checks: %0d, mismatches: %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // One-byte command frame
    task automatic cmd(input logic [7:0] op);
        m.start();
        m.xfer(op, rx, 8);
        m.stop();
    endtask

    // Opcode, address high then low, then n data bytes
    task automatic frame(input logic [7:0] op, input logic [15:0] a,
        input int n, input int hb);
        m.start();
        m.xfer(op, rx, 8);
        m.xfer(a[15:8], rx, 8);
        m.xfer(a[7:0], rx, 8);
        for (int i = 0; i < n; i++)
            m.xfer(wbuf[i], rbuf[i], i == 0 ? hb : 8);
        m.stop();
    endtask

    // Bounded wait for the write cycle to end
    task automatic wait_idle();
        for (int i = 0; i < 2 * WCYC && BUSY !== 1'b0; i++)
            @(negedge CLK);
        // Status output lags busy by one clock
        @(negedge CLK);
        check({7'h0, BUSY}, 8'h00);
    endtask

    // Status read of one byte
    task automatic sr_rd(input logic [7:0] op, output logic [7:0] v);
        m.start();
        m.xfer(op, rx, 8);
        m.xfer(8'h00, v, 8);
        m.stop();
    endtask

    task automatic wr(input logic [15:0] a, input int n);
        cmd(8'h06);
        frame(8'h02, a, n, 8);
        wait_idle();
    endtask

    task automatic sr_wr(input logic [7:0] v);
        cmd(8'h06);
        m.start();
        m.xfer(8'h01, rx, 8);
        m.xfer(v, rx, 8);
        m.stop();
        wait_idle();
    endtask

    // Protected region for 8 address bits
    function automatic bit prot(input logic [7:0] a, input int bp);
        return bp == 3 || (bp == 2 && a >= 8'h80) ||
            (bp == 1 && a >= 8'hc0);
    endfunction

    // Main sequence
    initial begin
        RESET = 1'b1;
        WP_N = 1'b1;
        repeat (5) @(posedge CLK);
        @(negedge CLK);
        RESET = 1'b0;
        m.tick(4);
        check(STATUS, 8'h00);
        sr_rd(8'h0d, rx);
        check(rx, 8'h00);
        cmd(8'h0e);
        check(STATUS, 8'h02);
        cmd(8'h04);
        check(STATUS, 8'h00);
        // Page write crossing the page end
        wbuf = '{8'h11, 8'h22, 8'h33, 8'h00};
        cmd(8'h06);
        frame(8'h02, 16'h003f, 3, 8);
        check({7'h0, BUSY}, 8'h01);
        sr_rd(8'h05, rx);
        check(rx, 8'hff);
        check(STATUS, 8'hff);
        m.start();
        m.xfer(8'h03, rx, 8);
        m.tick(4);
        check({5'h0, PHASE}, {5'h0, ST_IGNORE});
        m.stop();
        wait_idle();
        check(STATUS, 8'h00);
        wbuf[0] = 8'h44;
        wr(16'h00ff, 1);
        // Read over the top with a pause inside the first byte
        frame(8'h03, 16'h00ff, 3, 5);
        check(rbuf[0], 8'h44);
        check(rbuf[1], 8'h22);
        check(rbuf[2], 8'h33);
        check({7'h0, m.paused_oe}, 8'h00);
        frame(8'h03, 16'ha03f, 1, 8);
        check(rbuf[0], 8'h11);
        // Write attempt with the latch clear
        wbuf[0] = 8'h55;
        frame(8'h02, 16'h003f, 1, 8);
        check({7'h0, BUSY}, 8'h00);
        frame(8'h03, 16'h003f, 1, 8);
        check(rbuf[0], 8'h11);
        // Unknown opcode
        m.start();
        m.xfer(8'h07, rx, 8);
        m.tick(8);
        check({5'h0, PHASE}, {5'h0, ST_IGNORE});
        check({7'h0, SO_OE}, 8'h00);
        m.stop();
        check({7'h0, SO_OE}, 8'h00);
        // Every protect level; pin low but enable clear
        WP_N = 1'b0;
        for (int k = 0; k < 4; k++) begin
            sr_wr({4'h0, k[1:0], 2'h0});
            check(STATUS, {4'h0, k[1:0], 2'h0});
            for (int p = 0; p < 3; p++) begin
                wbuf[0] = 8'(160 + 4 * k + p);
                wr({8'h00, probe[p]}, 1);
                if (!prot(probe[p], k))
                    mir[p] = wbuf[0];
            end
            for (int p = 0; p < 3; p++) begin
                frame(8'h03, {8'h00, probe[p]}, 1, 8);
                check(rbuf[0], mir[p]);
            end
        end
        sr_wr(8'h80);
        check(STATUS, 8'h80);
        sr_wr(8'h00);
        check(STATUS & 8'hfc, 8'h80);
        WP_N = 1'b1;
        sr_wr(8'h00);
        check(STATUS, 8'h00);
        conclude();
    end

    // Watchdog, well beyond the expected run length
    initial begin
        #2000000;
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
